// File: hdl/tsense_consts.svh
`ifndef TSENSE_CONSTS_SVH
`define TSENSE_CONSTS_SVH
// Sensor register pointers
`define PTR_CAPABILITY   8'h00
`define PTR_CONFIG       8'h01
`define PTR_UPPER        8'h02
`define PTR_LOWER        8'h03
`define PTR_CRITICAL     8'h04
`define PTR_TEMPERATURE  8'h05
`define PTR_MAKER_ID     8'h06
`define PTR_PART_ID      8'h07
`define PTR_TIMEOUT      8'h22
`define PTR_RESET        8'h00
// Fixed values and resets
`define CAPABILITY_VAL   16'h00D7
`define REG_RESET        16'h0000
`define CFG_WR_MASK      16'h07CD
`define CFG_HYS_MASK     16'h0600
`define BUS_ADDR_HIGH    4'b0011
// Configuration fields
`define CFG_MODE         0
`define CFG_CRIT_ONLY    2
`define CFG_OUT_EN       3
`define CFG_STATUS       4
`define CFG_CLEAR        5
`define CFG_WIN_LOCK     6
`define CFG_CRIT_LOCK    7
`define CFG_SHUTDOWN     8
`define CFG_HYS_LO       9
`define CFG_HYS_HI       10
// Hysteresis in 1/16 degree steps
`define HYS_1P5          14'sd24
`define HYS_3P0          14'sd48
`define HYS_6P0          14'sd96
// Timing
`define CORE_CLK_KHZ     200000
`define BUS_BUS_STUCK_TIMEOUT_MIN_US  25000
`define SCL_RATE_KHZ     100
// Controller APB map
`define APB_CMD          8'h00
`define APB_WDATA        8'h04
`define APB_STATUS       8'h08
`define APB_RDATA        8'h0C
`endif

// File: hdl/tsense_pkg.sv
package tsense_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_PTR = 3'b011, S_WDAT = 3'b010, S_RDAT = 3'b110
  } slv_state_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_START = 2'b01, M_BITS = 2'b11, M_STOP = 2'b10
  } mst_state_t;
endpackage

// File: hdl/tsense_if.sv
`timescale 1ns/100ps
interface tsense_if;
  logic scl_oe;
  logic sda_oe_host;
  logic sda_oe_dev;
  logic event_oe;
  logic scl;
  logic sda;
  logic event_n;
  // Open drain wires with pull-ups
  assign scl     = ~scl_oe;
  assign sda     = ~(sda_oe_host | sda_oe_dev);
  assign event_n = ~event_oe;
  modport dev  (input scl, input sda, output sda_oe_dev, output event_oe);
  modport host (input scl, input sda, input event_n, output scl_oe, output sda_oe_host);
endinterface

// File: hdl/sensor_bus_master.sv
`timescale 1ns/100ps
`include "tsense_consts.svh"
module sensor_bus_master #(
  parameter int QUARTER_CYC = `CORE_CLK_KHZ / (`SCL_RATE_KHZ * 4)
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire link
  tsense_if.host           link
);
  import tsense_pkg::*;
  if (QUARTER_CYC < 8 || QUARTER_CYC > 65535) begin : g_bad_quarter
    $error("QUARTER_CYC out of range");
  end

  tsense_pkg::mst_state_t st_ff;
  logic [15:0] div_ff;
  logic        tick;
  logic [1:0]  ph_ff, idx_ff, last_idx;
  logic [3:0]  bitn_ff;
  logic [7:0]  tx_ff, ptr_ff;
  logic [15:0] wdat_ff, rx_ff;
  logic [2:0]  strap_ff;
  logic        rd_ff, ptr_only_ff, nack_ff, scl_oe_ff, sda_oe_ff, rd_phase, busy;
  logic [1:0]  s1_ff, s2_ff, s3_ff, pin_ff;
  logic        acc, wr_cmd;

  // Link inputs: sda and alarm pin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= 2'b11;
      s2_ff  <= 2'b11;
      s3_ff  <= 2'b11;
      pin_ff <= 2'b11;
    end else begin
      s1_ff  <= {link.event_n, link.sda};
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      pin_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & pin_ff);
    end
  end

  assign busy     = (st_ff != M_IDLE);
  assign acc      = psel & penable;
  assign wr_cmd   = acc & pwrite & (paddr == `APB_CMD) & ~busy;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~(paddr inside {`APB_CMD, `APB_WDATA, `APB_STATUS, `APB_RDATA});
  assign tick     = busy & (div_ff == 16'(QUARTER_CYC - 1));
  assign rd_phase = rd_ff & (idx_ff != 2'b00);
  assign last_idx = rd_ff ? 2'd2 : (ptr_only_ff ? 2'd1 : 2'd3);
  assign link.scl_oe      = scl_oe_ff;
  assign link.sda_oe_host = sda_oe_ff;

  function automatic logic [7:0] byte_of(input logic [1:0] i);
    case (i)
      2'd0:    byte_of = {`BUS_ADDR_HIGH, strap_ff, rd_ff};
      2'd1:    byte_of = ptr_ff;
      2'd2:    byte_of = wdat_ff[15:8];
      default: byte_of = wdat_ff[7:0];
    endcase
  endfunction

  // Register reads, data valid in the access phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      case (paddr)
        `APB_CMD:    prdata <= {19'h0_0000, strap_ff, ptr_only_ff, rd_ff, ptr_ff};
        `APB_WDATA:  prdata <= {16'h0000, wdat_ff};
        `APB_STATUS: prdata <= {29'h0000_0000, ~pin_ff[1], nack_ff, busy};
        `APB_RDATA:  prdata <= {16'h0000, rx_ff};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Command fields; a command while busy is dropped
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_ff      <= 8'h00;
      rd_ff       <= 1'b0;
      ptr_only_ff <= 1'b0;
      strap_ff    <= 3'b000;
      wdat_ff     <= 16'h0000;
    end else begin
      if (wr_cmd) begin
        ptr_ff      <= pwdata[7:0];
        rd_ff       <= pwdata[8];
        ptr_only_ff <= pwdata[9];
        strap_ff    <= pwdata[12:10];
      end
      if (acc & pwrite & (paddr == `APB_WDATA) & ~busy)
        wdat_ff <= pwdata[15:0];
    end
  end

  // Quarter-bit divider; the master makes the serial clock itself
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      div_ff <= 16'h0000;
    else if (!busy || tick)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // Framing engine: start, address, pointer, data words, stop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff     <= M_IDLE;
      ph_ff     <= 2'd0;
      idx_ff    <= 2'd0;
      bitn_ff   <= 4'd0;
      tx_ff     <= 8'h00;
      rx_ff     <= 16'h0000;
      nack_ff   <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (wr_cmd) begin
      st_ff   <= M_START;
      ph_ff   <= 2'd0;
      nack_ff <= 1'b0;
    end else if (tick) begin
      ph_ff <= ph_ff + 2'd1;
      case (st_ff)
        M_START: begin
          case (ph_ff)
            2'd0: sda_oe_ff <= 1'b0;
            2'd1: sda_oe_ff <= 1'b1;
            2'd2: scl_oe_ff <= 1'b1;
            default: begin
              st_ff   <= M_BITS;
              idx_ff  <= 2'd0;
              bitn_ff <= 4'd0;
              tx_ff   <= byte_of(2'd0);
            end
          endcase
        end
        M_BITS: begin
          case (ph_ff)
            2'd0: begin
              if (bitn_ff < 4'd8)
                sda_oe_ff <= ~rd_phase & ~tx_ff[7];
              else
                sda_oe_ff <= rd_phase & (idx_ff != last_idx);
            end
            2'd1: scl_oe_ff <= 1'b0;
            2'd2: begin
              if (bitn_ff < 4'd8) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                if (rd_phase)
                  rx_ff <= {rx_ff[14:0], pin_ff[0]};
              end else if (!rd_phase && pin_ff[0]) begin
                nack_ff <= 1'b1;
              end
            end
            default: begin
              scl_oe_ff <= 1'b1;
              if (bitn_ff != 4'd8) begin
                bitn_ff <= bitn_ff + 4'd1;
              end else if (idx_ff == last_idx || nack_ff) begin
                st_ff <= M_STOP;
              end else begin
                idx_ff  <= idx_ff + 2'd1;
                tx_ff   <= byte_of(idx_ff + 2'd1);
                bitn_ff <= 4'd0;
              end
            end
          endcase
        end
        M_STOP: begin
          case (ph_ff)
            2'd0: sda_oe_ff <= 1'b1;
            2'd1: scl_oe_ff <= 1'b0;
            2'd2: sda_oe_ff <= 1'b0;
            default: st_ff <= M_IDLE;
          endcase
        end
        default: st_ff <= M_IDLE;
      endcase
    end
  end
endmodule // sensor_bus_master

// File: hdl/temp_sensor_end.sv
`timescale 1ns/100ps
`include "tsense_consts.svh"
// Notes on behaviour
// - Alarm has interrupt, comparator, critical modes
// - Interrupt alarm holds until clear bit written
// - Mode bit zero picks interrupt or comparator
// - Comparator alarm follows condition, self clears
// - Critical alarm holds until below limit minus hysteresis
// - Hysteresis applies to every threshold
// - Alarm fires entering and leaving window
// - Reset: limits zero, alarm off, comparator mode
// - Host programs limits and configuration first
// - Stuck-low clock resets interface when enabled
// - Host keeps clock at least 10 kHz
// - Pointer byte selects 16-bit registers
// - Write-only reads zero, read-only ignores writes
// - Fixed pointer map, reserved reads zero
// - Host avoids writing reserved pointers
// - Pointer is write-only, resets to 00h
// - Capability reads fixed 00D7h
// - Shutdown releases alarm pin, restores as soon as shutdown clears
// - Timeout stays active in shutdown
// - Bus address 0011 plus three straps
// - Hysteresis 0/1.5/3/6, falling temperature only
module temp_sensor_end #(
  parameter int          BUS_STUCK_TIMEOUT_CYC  = `BUS_BUS_STUCK_TIMEOUT_MIN_US * (`CORE_CLK_KHZ / 1000),
  parameter logic [15:0] MAKER_ID  = 16'h0A5A, // Arbitrary
  parameter logic [15:0] PART_ID   = 16'h0B01  // Arbitrary
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Two-wire link
  tsense_if.dev            link,
  // Straps
  input  wire logic        address_strap_high,
  input  wire logic        address_strap_mid,
  input  wire logic        address_strap_low,
  input  wire logic        bus_timeout_enable,
  // Converter side
  input  wire logic        temp_valid,
  input  wire logic [12:0] temp_value,
  output logic             conversion_enable,
  output logic             alarm_active
);
  import tsense_pkg::*;
  // Watchdog counter is 23 bits wide
  if (BUS_STUCK_TIMEOUT_CYC < 16 || BUS_STUCK_TIMEOUT_CYC > 8388607) begin : g_bad_bus_stuck_timeout
    $error("BUS_STUCK_TIMEOUT_CYC out of range");
  end

  logic [5:0]  p1_ff, p2_ff, p3_ff, pin_ff;
  logic        scl_d_ff, sda_d_ff, scl_rise, scl_fall, start_c, stop_c;
  tsense_pkg::slv_state_t st_ff;
  logic [3:0]  cnt_ff;
  logic [7:0]  sh_ff, ptr_ff, msb_ff;
  logic        wbyte_ff, rbyte_ff, oe_ff, bus_stuck_timeout_hit;
  logic [22:0] bus_stuck_timeout_ff;
  logic [15:0] cfg_ff, upper_ff, lower_ff, crit_ff, rd_word;
  logic [12:0] temp_ff;
  logic        reg_wr, over_up_ff, under_lo_ff, over_crit_ff, int_ff, evt;
  logic        nxt_up, nxt_lo, nxt_crit, conv;
  logic signed [13:0] t, hys;

  // Pin inputs: three stages, change taken once stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      p1_ff  <= 6'b00_0011;
      p2_ff  <= 6'b00_0011;
      p3_ff  <= 6'b00_0011;
      pin_ff <= 6'b00_0011;
    end else begin
      p1_ff  <= {bus_timeout_enable, address_strap_high, address_strap_mid,
                 address_strap_low, link.sda, link.scl};
      p2_ff  <= p1_ff;
      p3_ff  <= p2_ff;
      pin_ff <= (~(p2_ff ^ p3_ff) & p3_ff) | ((p2_ff ^ p3_ff) & pin_ff);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= pin_ff[0];
      sda_d_ff <= pin_ff[1];
    end
  end

  assign scl_rise = pin_ff[0] & ~scl_d_ff;
  assign scl_fall = ~pin_ff[0] & scl_d_ff;
  assign start_c  = pin_ff[0] & scl_d_ff & ~pin_ff[1] & sda_d_ff;
  assign stop_c   = pin_ff[0] & scl_d_ff & pin_ff[1] & ~sda_d_ff;
  assign link.sda_oe_dev = oe_ff;

  // Clock-low watchdog, independent of shutdown
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      bus_stuck_timeout_ff <= 23'd0;
    else if (pin_ff[0] || !pin_ff[5] || bus_stuck_timeout_hit)
      bus_stuck_timeout_ff <= 23'd0;
    else
      bus_stuck_timeout_ff <= bus_stuck_timeout_ff + 23'd1;
  end
  assign bus_stuck_timeout_hit = (bus_stuck_timeout_ff == 23'(BUS_STUCK_TIMEOUT_CYC - 1));

  // Register read view
  always_comb begin
    case (ptr_ff)
      `PTR_CAPABILITY:  rd_word = `CAPABILITY_VAL;
      `PTR_CONFIG:      rd_word = (cfg_ff & `CFG_WR_MASK) | (16'(evt) << `CFG_STATUS);
      `PTR_UPPER:       rd_word = upper_ff;
      `PTR_LOWER:       rd_word = lower_ff;
      `PTR_CRITICAL:    rd_word = crit_ff;
      `PTR_TEMPERATURE: rd_word = {over_crit_ff, over_up_ff, under_lo_ff, temp_ff};
      `PTR_MAKER_ID:    rd_word = MAKER_ID;
      `PTR_PART_ID:     rd_word = PART_ID;
      `PTR_TIMEOUT:     rd_word = {15'h0000, pin_ff[5]};
      default:          rd_word = 16'h0000;
    endcase
  end

  assign reg_wr = scl_fall & (cnt_ff == 4'd8) & (st_ff == S_WDAT) & wbyte_ff;

  // Serial slave
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= S_IDLE;
      cnt_ff   <= 4'd0;
      sh_ff    <= 8'h00;
      ptr_ff   <= `PTR_RESET;
      msb_ff   <= 8'h00;
      wbyte_ff <= 1'b0;
      rbyte_ff <= 1'b0;
      oe_ff    <= 1'b0;
    end else if (bus_stuck_timeout_hit || stop_c) begin
      st_ff <= S_IDLE;
      oe_ff <= 1'b0;
    end else if (start_c) begin
      st_ff  <= S_ADDR;
      cnt_ff <= 4'd0;
      oe_ff  <= 1'b0;
    end else if (st_ff == S_IDLE) begin
      oe_ff <= 1'b0;
    end else if (scl_rise) begin
      if (cnt_ff != 4'd8) begin
        sh_ff  <= {sh_ff[6:0], pin_ff[1]};
        cnt_ff <= cnt_ff + 4'd1;
      end else begin
        cnt_ff <= 4'd0;
        if (st_ff == S_RDAT && pin_ff[1])
          st_ff <= S_IDLE;
      end
    end else if (scl_fall) begin
      if (cnt_ff == 4'd8) begin
        oe_ff <= (st_ff != S_RDAT);
        case (st_ff)
          S_ADDR: begin
            if (sh_ff[7:1] == {`BUS_ADDR_HIGH, pin_ff[4:2]}) begin
              st_ff    <= sh_ff[0] ? S_RDAT : S_PTR;
              rbyte_ff <= 1'b0;
            end else begin
              st_ff <= S_IDLE;
              oe_ff <= 1'b0;
            end
          end
          S_PTR: begin
            ptr_ff   <= sh_ff;
            st_ff    <= S_WDAT;
            wbyte_ff <= 1'b0;
          end
          S_WDAT: begin
            msb_ff   <= sh_ff;
            wbyte_ff <= ~wbyte_ff;
          end
          S_RDAT:  rbyte_ff <= ~rbyte_ff;
          default: st_ff <= S_IDLE;
        endcase
      end else if (st_ff == S_RDAT) begin
        oe_ff <= ~(rbyte_ff ? rd_word[7 - cnt_ff[2:0]] : rd_word[15 - cnt_ff[2:0]]);
      end else begin
        oe_ff <= 1'b0;
      end
    end
  end

  // Writable registers; read-only pointers fall through untouched
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff   <= `REG_RESET;
      upper_ff <= `REG_RESET;
      lower_ff <= `REG_RESET;
      crit_ff  <= `REG_RESET;
    end else if (reg_wr) begin
      case (ptr_ff)
        `PTR_CONFIG: begin
          if (cfg_ff[`CFG_WIN_LOCK] | cfg_ff[`CFG_CRIT_LOCK])
            cfg_ff <= ({msb_ff, sh_ff} & `CFG_WR_MASK & ~`CFG_HYS_MASK)
                      | (cfg_ff & `CFG_HYS_MASK);
          else
            cfg_ff <= {msb_ff, sh_ff} & `CFG_WR_MASK;
        end
        `PTR_UPPER:    upper_ff <= {msb_ff, sh_ff};
        `PTR_LOWER:    lower_ff <= {msb_ff, sh_ff};
        `PTR_CRITICAL: crit_ff  <= {msb_ff, sh_ff};
        default: ;
      endcase
    end
  end

  // Alarm evaluation
  always_comb begin
    case (cfg_ff[`CFG_HYS_HI:`CFG_HYS_LO])
      2'b01:   hys = `HYS_1P5;
      2'b10:   hys = `HYS_3P0;
      2'b11:   hys = `HYS_6P0;
      default: hys = 14'sd0;
    endcase
  end

  assign t    = signed'({temp_value[12], temp_value});
  assign conv = temp_valid & ~cfg_ff[`CFG_SHUTDOWN];
  // Hysteresis acts only on the way down: delays upper and critical clears and the lower set
  assign nxt_up   = over_up_ff ? (t >= signed'({upper_ff[12], upper_ff[12:0]}) - hys)
                               : (t > signed'({upper_ff[12], upper_ff[12:0]}));
  assign nxt_crit = over_crit_ff ? (t >= signed'({crit_ff[12], crit_ff[12:0]}) - hys)
                                 : (t > signed'({crit_ff[12], crit_ff[12:0]}));
  assign nxt_lo   = under_lo_ff ? (t <= signed'({lower_ff[12], lower_ff[12:0]}))
                                : (t < signed'({lower_ff[12], lower_ff[12:0]}) - hys);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      temp_ff      <= 13'h0000;
      over_up_ff   <= 1'b0;
      under_lo_ff  <= 1'b0;
      over_crit_ff <= 1'b0;
    end else if (conv) begin
      temp_ff      <= temp_value;
      over_up_ff   <= nxt_up;
      under_lo_ff  <= nxt_lo;
      over_crit_ff <= nxt_crit;
    end
  end

  // Sticky interrupt; a new crossing wins over the clear bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      int_ff <= 1'b0;
    else if (conv && ((nxt_up | nxt_lo) != (over_up_ff | under_lo_ff)))
      int_ff <= 1'b1;
    else if (reg_wr && ptr_ff == `PTR_CONFIG && sh_ff[`CFG_CLEAR])
      int_ff <= 1'b0;
  end

  // Mode select and pin drive
  always_comb begin
    if (!cfg_ff[`CFG_OUT_EN])
      evt = 1'b0;
    else if (cfg_ff[`CFG_CRIT_ONLY])
      evt = over_crit_ff;
    else if (cfg_ff[`CFG_MODE])
      evt = over_crit_ff | int_ff;
    else
      evt = over_crit_ff | over_up_ff | under_lo_ff;
  end

  // Shutdown floats the pin but keeps alarm state for the return
  assign link.event_oe     = evt & ~cfg_ff[`CFG_SHUTDOWN];
  assign alarm_active      = evt;
  assign conversion_enable = ~cfg_ff[`CFG_SHUTDOWN];
endmodule // temp_sensor_end

// File: bench/tsense_checker.sv
`timescale 1ns/100ps
module tsense_checker #(
  parameter int QUARTER_CYC = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link drivers and wires
  input wire logic scl_oe,
  input wire logic sda_oe_host,
  input wire logic sda_oe_dev,
  input wire logic event_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic event_n
);
  logic       scl_d_ff;
  logic       sda_d_ff;
  logic       in_frame_ff;
  logic       first_byte_ff;
  logic [3:0] bit_cnt_ff;
  int         low_cnt_ff;
  wire        start_w = scl && scl_d_ff && sda_d_ff && !sda;
  wire        stop_w  = scl && scl_d_ff && !sda_d_ff && sda;
  wire        rise_w  = scl && !scl_d_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      in_frame_ff <= 1'b0;
    end else if (start_w) begin
      in_frame_ff <= 1'b1;
    end else if (stop_w) begin
      in_frame_ff <= 1'b0;
    end
  end

  // Ninth rise is the acknowledge slot
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_ff    <= 4'h0;
      first_byte_ff <= 1'b0;
    end else if (start_w) begin
      bit_cnt_ff    <= 4'h0;
      first_byte_ff <= 1'b1;
    end else if (rise_w && bit_cnt_ff == 4'h8) begin
      bit_cnt_ff    <= 4'h0;
      first_byte_ff <= 1'b0;
    end else if (rise_w) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt_ff <= 0;
    end else begin
      low_cnt_ff <= scl ? 0 : low_cnt_ff + 1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  reset_release_a: assert property ($rose(rstn) |-> !scl_oe && !sda_oe_dev && !event_oe)
    else $error("link driven right after reset");
  scl_low_bound_a: assert property (low_cnt_ff <= 4 * QUARTER_CYC)
    else $error("clock low too long");
  scl_high_min_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  scl_idle_a: assert property ($fell(scl) |-> in_frame_ff)
    else $error("clock moved outside a frame");
  dev_data_timing_a: assert property ($changed(sda_oe_dev) |-> !scl)
    else $error("device changed data while clock high");
  addr_byte_quiet_a: assert property (rise_w && first_byte_ff && bit_cnt_ff < 4'h8 |-> !sda_oe_dev)
    else $error("device drove data in address byte");
  no_contention_a: assert property (rise_w |-> !(sda_oe_dev && sda_oe_host))
    else $error("both ends drive data at clock rise");
  stop_release_a: assert property (stop_w |=> !sda_oe_dev [*8])
    else $error("device drove data after stop");
endmodule // tsense_checker

// File: bench/tb.sv
`timescale 1ns/100ps
`include "tsense_consts.svh"
module tb;
  import tsense_pkg::*;
  localparam logic [15:0] MAKER = 16'h0C3C; // Arbitrary
  localparam logic [15:0] PART  = 16'h0D02; // Arbitrary
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, st;
  logic        pready, pslverr, serr, conversion_enable, alarm_active;
  logic [2:0]  strap = 3'b101;
  logic        bus_stuck_timeout_en = 1'b0, temp_valid = 1'b0;
  logic [12:0] temp_value = 13'h0000;
  logic        above_m = 1'b0, below_m = 1'b0, crit_m = 1'b0, irq_m = 1'b0, alm_m;
  logic [7:0]  plist [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h22, 8'h10};
  int          mismatches = 0, samples_checked = 0;
  int          mreg [256];
  tsense_if link ();
  always #2.5 core_clk = ~core_clk;

  sensor_bus_master #(.QUARTER_CYC(16)) i_sensor_bus_master (.core_clk(core_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  temp_sensor_end #(.BUS_STUCK_TIMEOUT_CYC(200), .MAKER_ID(MAKER), .PART_ID(PART)) i_temp_sensor_end (
    .core_clk(core_clk), .rstn(rstn), .link(link), .address_strap_high(strap[2]),
    .address_strap_mid(strap[1]), .address_strap_low(strap[0]), .bus_timeout_enable(bus_stuck_timeout_en),
    .temp_valid(temp_valid), .temp_value(temp_value), .conversion_enable(conversion_enable),
    .alarm_active(alarm_active));
  tsense_checker #(.QUARTER_CYC(16)) i_tsense_checker (.core_clk(core_clk), .rstn(rstn),
    .scl_oe(link.scl_oe), .sda_oe_host(link.sda_oe_host), .sda_oe_dev(link.sda_oe_dev),
    .event_oe(link.event_oe), .scl(link.scl), .sda(link.sda), .event_n(link.event_n));

  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Kind is {pointer only, read}
  task automatic link_op(input logic [2:0] s, input logic [1:0] kind, input logic [7:0] p);
    int n;
    n = 0;
    apb(1'b1, `APB_CMD, {19'h0_0000, s, kind, p});
    do begin
      apb(1'b0, `APB_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
    if (rd[0] !== 1'b0) begin
      mismatches++;
      conclude();
    end
    st = rd;
  endtask

  task automatic dev_wr(input logic [7:0] p, input logic [15:0] w);
    apb(1'b1, `APB_WDATA, {16'h0000, w});
    link_op(strap, 2'b00, p);
    if (p == 8'h01) mreg[1] = w & 16'h07CD;
    if (p == 8'h01 && w[5]) irq_m = 1'b0;
    if (p >= 8'h02 && p <= 8'h04) mreg[p] = w;
    // Config writes change the pin at once, so the model follows them here
    alm_m = crit_m | (~mreg[1][2] & (mreg[1][0] ? irq_m : above_m | below_m));
  endtask

  task automatic dev_rd(input logic [7:0] p, input logic po);
    if (po) link_op(strap, 2'b10, p);
    link_op(strap, 2'b01, 8'h00);
    apb(1'b0, `APB_RDATA, 32'h0000_0000);
  endtask

  task automatic pin_chk();
    chk({31'h0, ~(alm_m & mreg[1][3] & ~mreg[1][8])}, {31'h0, link.event_n});
    chk({31'h0, ~mreg[1][8]}, {31'h0, conversion_enable});
  endtask

  task automatic conv(input logic [12:0] t);
    int ti, up, lo, cr, hy;
    logic win;
    ti = int'($signed(t));
    up = int'($signed(mreg[2][12:0]));
    lo = int'($signed(mreg[3][12:0]));
    cr = int'($signed(mreg[4][12:0]));
    hy = 24 * (mreg[1][10:9] == 2'd3 ? 4 : int'(mreg[1][10:9]));
    win = above_m | below_m;
    if (ti > up) above_m = 1'b1; else if (ti < up - hy) above_m = 1'b0;
    if (ti < lo - hy) below_m = 1'b1; else if (ti > lo) below_m = 1'b0;
    if (ti > cr) crit_m = 1'b1; else if (ti < cr - hy) crit_m = 1'b0;
    if (win != (above_m | below_m)) irq_m = 1'b1;
    alm_m = crit_m | (~mreg[1][2] & (mreg[1][0] ? irq_m : above_m | below_m));
    @(posedge core_clk);
    temp_value <= t;
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, alm_m}, {31'h0, alarm_active});
    pin_chk();
  endtask

  initial begin
    void'($urandom(32'h8b6c));
    foreach (mreg[i]) mreg[i] = 0;
    mreg[0] = 16'h00D7;
    mreg[6] = MAKER;
    mreg[7] = PART;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge core_clk);
    dev_rd(8'h00, 1'b0);
    chk(mreg[0], rd);
    for (int i = 0; i < 9; i++) begin
      dev_rd(plist[i], 1'b1);
      chk(mreg[plist[i]], rd);
    end
    bus_stuck_timeout_en <= 1'b1;
    mreg[8'h22] = 1;
    dev_rd(8'h22, 1'b1);
    chk(mreg[8'h22], rd);
    dev_wr(8'h00, 16'hFFFF);
    dev_rd(8'h00, 1'b0);
    chk(mreg[0], rd);
    for (int p = 2; p <= 4; p++) begin
      dev_wr(p[7:0], 16'($urandom) & 16'h1FF0);
      dev_rd(p[7:0], 1'b0);
      chk(mreg[p], rd);
    end
    link_op(strap ^ 3'b011, 2'b10, 8'h01);
    chk(32'h0000_0001, {31'h0, st[1]});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0, serr});
    dev_wr(8'h02, 16'h0100);
    dev_wr(8'h03, 16'h0000);
    dev_wr(8'h04, 16'h0300);
    dev_wr(8'h01, 16'h0008);
    conv(13'h0080);
    conv(13'h0200);
    dev_rd(8'h05, 1'b1);
    chk({crit_m, above_m, below_m, 13'h0200}, rd);
    conv(13'h0080);
    dev_wr(8'h01, 16'h0208);
    conv(13'h0200);
    conv(13'h00F0);
    conv(13'h00E0);
    dev_wr(8'h01, 16'h020C);
    conv(13'h0400);
    conv(13'h02F0);
    conv(13'h02E0);
    dev_wr(8'h01, 16'h0029);
    conv(13'h0080);
    conv(13'h0080);
    dev_wr(8'h01, 16'h0029);
    pin_chk();
    conv(13'h0200);
    dev_wr(8'h01, 16'h0008);
    conv(13'h0080);
    conv(13'h0200);
    dev_wr(8'h01, 16'h0108);
    chk(32'h0000_0001, {31'h0, alarm_active});
    pin_chk();
    dev_wr(8'h01, 16'h0008);
    pin_chk();
    apb(1'b0, `APB_STATUS, 32'h0000_0000);
    chk({31'h0, alm_m & mreg[1][3] & ~mreg[1][8]}, {31'h0, rd[2]});
    conclude();
  end
endmodule // tb
